// File: rtl/dcff_fifo.sv
// dual-clock 9-bit fifo with read- and write-clocked encoded flags
//
// Function
// - data outputs low after master reset release
// - read clock owns empty flags, write almost-full
// - opposite event after update edge is excluded
// - opposite event a period earlier is included
// - read edge reaching zero shows empty
// - read after write-to-empty is latent update
// - enabled read at zero count is ignored
// - disabled read edge refreshes flags, no decrement
// - leave almost-empty only above sixteen after read
// - almost-full at 2032 or 496 words
// - write edge reaching threshold shows almost-full if read state is above sixteen
// - disabled write edge still refreshes almost-full
// - flag pair encodes empty, low, middle, high
// - refuse writes when full, reads when empty
// - empty fifo holds last valid read data
`include "dcff_cfg.svh"

module dcff_fifo
(
  input  wire logic                    clk_sys_i,        // system clock
  input  wire logic                    rst_n_i,          // master reset
  input  wire logic                    clk_en_i,         // freezes all
  input  wire logic                    write_clock_i,    // write strobe
  input  wire logic                    write_enable_n_i, // write enable
  input  wire logic [`DCFF_DATA_W-1:0] data_in_i,        // write data
  input  wire logic                    read_clock_i,     // read strobe
  input  wire logic                    read_enable_n_i,  // read enable
  output logic      [`DCFF_DATA_W-1:0] data_out_o,       // read data
  output logic                         flag_out_a_o,     // flag bit a
  output logic                         flag_out_b_o      // flag bit b
);

  // almost-full threshold for the built depth
  localparam logic [`DCFF_PTR_W-1:0] AF_LVL =
    (`DCFF_DEPTH_CNT == 12'h800) ? `DCFF_AF_LVL_2K
                                 : `DCFF_AF_LVL_512;

  // previous level of each strobe, for edge detection
  logic                       wr_clk_prev_reg;  // write strobe last
  logic                       rd_clk_prev_reg;  // read strobe last
  logic                       wr_edge;          // write strobe rises
  logic                       rd_edge;          // read strobe rises

  // pointers, one per side
  logic [`DCFF_PTR_W-1:0]     wr_ptr_reg;       // write pointer
  logic [`DCFF_PTR_W-1:0]     rd_ptr_reg;       // read pointer
  logic [`DCFF_PTR_W-1:0]     wr_cnt;           // count seen by writer
  logic [`DCFF_PTR_W-1:0]     wr_cnt_next;      // count after push
  logic [`DCFF_PTR_W-1:0]     rd_cnt;           // count seen by reader
  logic [`DCFF_PTR_W-1:0]     rd_cnt_next;      // count after pop
  logic                       wr_push;          // word stored now
  logic                       rd_pop;           // word fetched now
  logic                       pop_d_reg;        // fetch one cycle ago

  // flag state
  logic                       af_reg;           // almost-full state
  dcff_pkg::dcff_rd_state_type rd_state_reg;    // read-side state
  dcff_pkg::dcff_rd_state_type rd_state_next;   // state after edge

  // outputs
  logic [`DCFF_DATA_W-1:0]    data_out_reg;     // held read data
  logic [`DCFF_DATA_W-1:0]    mem_rdata;        // fetched word
  logic                       flag_a_reg;       // flag a driver
  logic                       flag_b_reg;       // flag b driver

  // maps flag state onto the two pins
  function automatic logic [1:0] flag_enc
  (
    input dcff_pkg::dcff_rd_state_type st,
    input logic                        af
  );
    logic [1:0] enc;
    enc = `DCFF_ENC_MID;
    case (st)
      dcff_pkg::DCFF_EMPTY:        enc = `DCFF_ENC_EMPTY;
      dcff_pkg::DCFF_ALMOST_EMPTY: enc = `DCFF_ENC_AEMPTY;
      dcff_pkg::DCFF_ABOVE:
        enc = af ? `DCFF_ENC_AFULL : `DCFF_ENC_MID;
      default:                     enc = `DCFF_ENC_EMPTY;
    endcase
    return enc;
  endfunction : flag_enc

  // strobe edges, inputs already synchronous to clk_sys_i
  assign wr_edge = write_clock_i & ~wr_clk_prev_reg;
  assign rd_edge = read_clock_i & ~rd_clk_prev_reg;

  // writer sees reads done before this cycle only
  assign wr_cnt      = wr_ptr_reg - rd_ptr_reg;
  assign wr_push     = clk_en_i & wr_edge & ~write_enable_n_i
                     & (wr_cnt != `DCFF_DEPTH_CNT);
  assign wr_cnt_next = wr_cnt + {{(`DCFF_PTR_W-1){1'b0}}, wr_push};

  // reader pops only when its own flags show data
  assign rd_cnt  = wr_ptr_reg - rd_ptr_reg;
  assign rd_pop  = clk_en_i & rd_edge & ~read_enable_n_i
                 & (rd_state_reg != dcff_pkg::DCFF_EMPTY);
  assign rd_cnt_next = rd_cnt - {{(`DCFF_PTR_W-1){1'b0}}, rd_pop};

  // read-side state after this read edge
  assign rd_state_next =
    (rd_cnt_next == '0)           ? dcff_pkg::DCFF_EMPTY :
    (rd_cnt_next <= `DCFF_AE_MAX) ? dcff_pkg::DCFF_ALMOST_EMPTY :
                                    dcff_pkg::DCFF_ABOVE;

  // strobe history
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_clk_prev_reg <= 1'b0;
      rd_clk_prev_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      wr_clk_prev_reg <= write_clock_i;
      rd_clk_prev_reg <= read_clock_i;
    end
  end

  // write pointer, cleared by master reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_reg <= '0;
    end
    else if (wr_push)
    begin
      wr_ptr_reg <= wr_ptr_reg + 12'h001;
    end
  end

  // almost-full state, write strobe only, enabled or not
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      af_reg <= 1'b0;
    end
    else if (clk_en_i && wr_edge)
    begin
      af_reg <= (wr_cnt_next >= AF_LVL);
    end
  end

  // read pointer, cleared by master reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_ptr_reg <= '0;
    end
    else if (rd_pop)
    begin
      rd_ptr_reg <= rd_ptr_reg + 12'h001;
    end
  end

  // read-side state, every read edge refreshes it
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_state_reg <= dcff_pkg::DCFF_EMPTY;
    end
    else if (clk_en_i && rd_edge)
    begin
      rd_state_reg <= rd_state_next;
    end
  end

  // fetch marker for the output register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pop_d_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pop_d_reg <= rd_pop;
    end
  end

  // output data, only a real fetch changes it
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data_out_reg <= '0;
    end
    else if (clk_en_i && pop_d_reg)
    begin
      data_out_reg <= mem_rdata;
    end
  end

  // flag pins, registered from both owners
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      {flag_a_reg, flag_b_reg} <= flag_enc(rd_state_reg, af_reg);
    end
  end

  // storage
  dcff_mem u_mem
  (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (wr_push),
    .wr_addr_i (wr_ptr_reg[`DCFF_ADDR_W-1:0]),
    .wr_data_i (data_in_i),
    .rd_en_i   (rd_pop),
    .rd_addr_i (rd_ptr_reg[`DCFF_ADDR_W-1:0]),
    .rd_data_o (mem_rdata)
  );

  assign data_out_o   = data_out_reg;
  assign flag_out_a_o = flag_a_reg;
  assign flag_out_b_o = flag_b_reg;

  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  // helper: any fetch since reset
  logic ever_pop_reg;  // a real read has happened
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ever_pop_reg <= 1'b0;
    end
    else if (rd_pop)
    begin
      ever_pop_reg <= 1'b1;
    end
  end

  // read edge that leaves zero words, then a running cycle
  sequence seq_rd_to_zero;
    clk_en_i && rd_edge && (rd_cnt_next == '0) ##1 clk_en_i;
  endsequence

  // read edge while flags still show empty
  sequence seq_latent;
    clk_en_i && rd_edge && (rd_state_reg == dcff_pkg::DCFF_EMPTY);
  endsequence
  AST_DATA_LOW_AFTER_RST: assert property (
    !ever_pop_reg |-> (data_out_o == '0))
    else $error("data not low after reset");
  AST_EMPTY_PINS: assert property (
    seq_rd_to_zero |=> (!flag_out_a_o && !flag_out_b_o))
    else $error("empty not shown after read to zero");
  AST_LATENT_NO_CHANGE: assert property (
    seq_latent |=> $stable(rd_ptr_reg) ##1 $stable(data_out_o))
    else $error("latent read changed count or data");
  AST_DISABLED_READ: assert property (
    (clk_en_i && rd_edge && read_enable_n_i) |=> $stable(rd_ptr_reg))
    else $error("disabled read moved the read pointer");
  AST_RD_STATE_OWNER: assert property (
    !(clk_en_i && rd_edge) |=> $stable(rd_state_reg))
    else $error("read state changed without read edge");
  AST_AF_OWNER: assert property (
    !(clk_en_i && wr_edge) |=> $stable(af_reg))
    else $error("almost-full changed without write edge");
  AST_AF_SET: assert property (
    (clk_en_i && wr_edge && (wr_cnt_next >= AF_LVL)) |=> af_reg)
    else $error("almost-full not set at threshold");
  AST_NO_OVERFLOW: assert property (
    (wr_cnt == `DCFF_DEPTH_CNT) |=> $stable(wr_ptr_reg))
    else $error("write accepted while full");
  AST_EXCLUDE_SAME: assert property (
    (clk_en_i && rd_edge && wr_push && (rd_cnt == '0))
      |=> (rd_state_reg == dcff_pkg::DCFF_EMPTY))
    else $error("same-cycle write counted by read edge");
  AST_INCLUDE_EARLIER: assert property (
    (clk_en_i && rd_edge && (rd_cnt > 12'h001))
      |=> (rd_state_reg != dcff_pkg::DCFF_EMPTY))
    else $error("earlier write not counted by read edge");

endmodule : dcff_fifo

// File: rtl/dcff_mem.sv
// storage array with one write port and a registered read port
`include "dcff_cfg.svh"

module dcff_mem
(
  input  wire logic                    clk_sys_i,  // system clock
  input  wire logic                    rst_n_i,    // async reset, low
  input  wire logic                    wr_en_i,    // store a word
  input  wire logic [`DCFF_ADDR_W-1:0] wr_addr_i,  // write address
  input  wire logic [`DCFF_DATA_W-1:0] wr_data_i,  // write data
  input  wire logic                    rd_en_i,    // fetch a word
  input  wire logic [`DCFF_ADDR_W-1:0] rd_addr_i,  // read address
  output logic      [`DCFF_DATA_W-1:0] rd_data_o   // registered data
);

  // word array, no reset so it maps to ram
  logic [`DCFF_DATA_W-1:0] mem_array [`DCFF_DEPTH];

  // write port
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en_i)
    begin
      mem_array[wr_addr_i] <= wr_data_i;
    end
  end

  // read port, data held until next fetch
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_o <= '0;
    end
    else if (rd_en_i)
    begin
      rd_data_o <= mem_array[rd_addr_i];
    end
  end

endmodule : dcff_mem

// File: shared/dcff_cfg.svh
// constants for the dual-clock fifo with encoded status flags
`ifndef DCFF_CFG_SVH
`define DCFF_CFG_SVH

// storage shape
`define DCFF_DATA_W      9
`define DCFF_DEPTH       2048
`define DCFF_ADDR_W      11
`define DCFF_PTR_W       12

// word-count thresholds, at pointer width
`define DCFF_DEPTH_CNT   12'h800
`define DCFF_AE_MAX      12'h010
`define DCFF_AF_LVL_2K   12'h7f0
`define DCFF_AF_LVL_512  12'h1f0

// flag encodings {flag_out_a, flag_out_b}
`define DCFF_ENC_EMPTY   2'h0
`define DCFF_ENC_AEMPTY  2'h2
`define DCFF_ENC_MID     2'h3
`define DCFF_ENC_AFULL   2'h1

// opposite-clock recognition windows
`define DCFF_CLK_NS      4
`define DCFF_EXCLUDE_NS  0
`define DCFF_INCLUDE_NS  12
`define DCFF_INCLUDE_CYC \
  ((`DCFF_INCLUDE_NS + `DCFF_CLK_NS - 1) / `DCFF_CLK_NS)

`endif

// File: shared/dcff_pkg.sv
// types shared by the dual-clock fifo design files
package dcff_pkg;

  // read-side flag state, owned by the read clock
  typedef enum logic [1:0]
  {
    DCFF_EMPTY,
    DCFF_ALMOST_EMPTY,
    DCFF_ABOVE
  } dcff_rd_state_type;

endpackage : dcff_pkg

// File: test/dcff_fifo_test.sv
// self-checking bench for the dual-clock fifo
`include "dcff_cfg.svh"

module dcff_fifo_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_sys_i = 1'b0; // system clock
  logic       rst_n_i;          // master reset, low
  logic       clk_en = 1'b1;    // clock enable, low freezes
  logic       wr_clk;           // write strobe
  logic       wr_en_n;          // write enable, low
  logic [8:0] wr_data;          // write data
  logic       rd_clk;           // read strobe
  logic       rd_en_n;          // read enable, low
  logic [8:0] data_out;         // read data
  logic       flag_a;           // flag bit a
  logic       flag_b;           // flag bit b
  logic [8:0] prev_data = 9'h000; // last data seen
  logic [8:0] stored[$];        // words held by the fifo
  logic [8:0] expect_q[$];      // data expected on the output
  int         failures = 0;
  int         comparisons = 0;
  int         cycles = 0;       // timeout counter
  int         wseq = 0;         // accepted writes so far

  // 250 MHz clock
  always #2 clk_sys_i = ~clk_sys_i;

  dcff_partner i_partner
  (
    .clk_sys_i (clk_sys_i),
    .wr_clk_o  (wr_clk),
    .wr_en_n_o (wr_en_n),
    .wr_data_o (wr_data),
    .rd_clk_o  (rd_clk),
    .rd_en_n_o (rd_en_n)
  );

  dcff_fifo i_dut
  (
    .clk_sys_i        (clk_sys_i),
    .rst_n_i          (rst_n_i),
    .clk_en_i         (clk_en),
    .write_clock_i    (wr_clk),
    .write_enable_n_i (wr_en_n),
    .data_in_i        (wr_data),
    .read_clock_i     (rd_clk),
    .read_enable_n_i  (rd_en_n),
    .data_out_o       (data_out),
    .flag_out_a_o     (flag_a),
    .flag_out_b_o     (flag_b)
  );

  // compare and count, callable from both processes
  task automatic check(input string what, input logic [8:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // verdict and end of run
  task conclude;
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // flags are looked at once the update has reached the pins
  task flags(input logic [1:0] exp);
    repeat (3) @(negedge clk_sys_i);
    check("flags", {7'h00, exp}, {7'h00, flag_a, flag_b});
  endtask : flags

  // one operation; notes stored words and expected read data
  task step(input logic w, wen_n, r, ren_n, input bit pop);
    logic [8:0] d;
    d = {8'($urandom()), ~wseq[0]}; // neighbours always differ
    if (pop)
      expect_q.push_back(stored.pop_front());
    if (w && !wen_n && stored.size() < 2048)
    begin
      stored.push_back(d);
      wseq++;
    end
    i_partner.op(w, wen_n, r, ren_n, d);
  endtask : step

  // output watcher: each data change takes the oldest note
  // looks at the falling edge, where the data output has settled
  always @(negedge clk_sys_i)
  begin
    if (data_out !== prev_data)
    begin
      if (expect_q.size() == 0)
        check("data", prev_data, data_out);
      else
        check("data", expect_q.pop_front(), data_out);
    end
    prev_data = data_out;
    cycles++;
    if (cycles > 30000)
    begin
      failures++;
      conclude();
    end
  end

  // main sequence
  initial
  begin
    rst_n_i = 1'b0;
    void'($urandom(17));
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    check("data", 9'h000, data_out);
    flags(2'h0);
    step(0, 1, 1, 0, 0);
    flags(2'h0);
    step(1, 0, 0, 1, 0);
    flags(2'h0);
    step(0, 1, 1, 1, 0);
    flags(2'h2);
    step(0, 1, 1, 0, 1);
    flags(2'h0);
    step(0, 1, 1, 0, 0);
    flags(2'h0);
    // strobes while the clock enable is low must leave no trace
    clk_en = 1'b0;
    i_partner.op(1, 0, 1, 0, 9'(~$urandom()));
    clk_en = 1'b1;
    step(0, 1, 1, 1, 0);
    flags(2'h0);
    // write and read edge in the same cycle
    step(1, 0, 1, 0, 0);
    flags(2'h0);
    step(0, 1, 1, 1, 0);
    flags(2'h2);
    repeat (15) step(1, 0, 0, 1, 0);
    step(0, 1, 1, 1, 0);
    flags(2'h2);
    step(1, 0, 0, 1, 0);
    flags(2'h2);
    step(0, 1, 1, 1, 0);
    flags(2'h3);
    repeat (2014) step(1, 0, 0, 1, 0);
    step(0, 1, 1, 1, 0);
    flags(2'h3);
    step(1, 0, 0, 1, 0);
    flags(2'h1);
    // fill to the top, then one more that must be dropped
    repeat (17) step(1, 0, 0, 1, 0);
    repeat (17) step(0, 1, 1, 0, 1);
    flags(2'h1);
    step(1, 1, 0, 1, 0);
    flags(2'h3);
    repeat (2031) step(0, 1, 1, 0, 1);
    flags(2'h0);
    step(0, 1, 1, 0, 0);
    flags(2'h0);
    // reset in mid-run with words stored
    repeat (3) step(1, 0, 0, 1, 0);
    step(0, 1, 1, 1, 0);
    flags(2'h2);
    if (data_out !== 9'h000)
      expect_q.push_back(9'h000);
    stored.delete();
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    check("data", 9'h000, data_out);
    step(0, 1, 1, 1, 0);
    flags(2'h0);
    repeat (4) @(negedge clk_sys_i);
    check("pending", 9'h000, 9'(expect_q.size()));
    conclude();
  end
endmodule : dcff_fifo_test

// File: test/dcff_partner.sv
// producer and consumer model that drives the fifo strobe pins
`include "dcff_cfg.svh"

module dcff_partner
(
  input  wire logic                    clk_sys_i, // system clock
  output logic                         wr_clk_o,  // write strobe
  output logic                         wr_en_n_o, // write enable, low
  output logic      [`DCFF_DATA_W-1:0] wr_data_o, // write data
  output logic                         rd_clk_o,  // read strobe
  output logic                         rd_en_n_o  // read enable, low
);
  timeunit 1ns;
  timeprecision 1ps;

  // strobes low and enables off until the first request
  initial
  begin
    wr_clk_o  = 1'b0;
    wr_en_n_o = 1'b1;
    rd_clk_o  = 1'b0;
    rd_en_n_o = 1'b1;
    wr_data_o = 9'h000;
  end

  // one strobe edge on either side, then idle for one cycle
  task op(input logic w, wen_n, r, ren_n,
          input logic [`DCFF_DATA_W-1:0] d);
    @(negedge clk_sys_i);
    wr_clk_o  = w;
    wr_en_n_o = wen_n;
    wr_data_o = d;
    rd_clk_o  = r;
    rd_en_n_o = ren_n;
    @(negedge clk_sys_i);
    // idle: strobes low, enables off, data no longer valid
    wr_clk_o  = 1'b0;
    rd_clk_o  = 1'b0;
    wr_en_n_o = 1'b1;
    rd_en_n_o = 1'b1;
    wr_data_o = ~d;
  endtask : op
endmodule : dcff_partner
